// ---- core/wfsc_ctrl.sv ----
// top of the wake-up, fast start-up and supply sequencing controller
`timescale 1ns/10ps
module wfsc_ctrl
   import wfsc_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   input  wire logic [WAKE_PINS-1:0] wake_pin_input_n_in,
   input  wire logic                 supply_monitor_wake_n_in,
   input  wire logic                 rtc_wake_n_in,
   input  wire logic                 real_time_timer_wake_n_in,
   input  wire logic                 sleep_mode_in,
   input  wire logic                 backup_req_in,
   input  wire logic                 main_system_clock_done_in,
   input  wire logic [1:0]           frc_freq_req_in,
   input  wire logic                 xtal32_en_req_in,
   input  wire logic                 xtal32_sel_req_in,
   output logic                      fast_startup_out,
   output logic                      psw_en_out,
   output logic                      vreg_en_out,
   output logic                      core_rst_out,
   output logic                      core_supply_en_out,
   output logic                      sram_supply_en_out,
   output logic                      frc_en_out,
   output logic [1:0]                frc_freq_sel_out,
   output logic                      main_system_clock_frc_out,
   output logic                      cpu_clk_en_out,
   output logic                      xtal32_en_out,
   output logic                      slow_sel_xtal_out
);
   wfsc_wake_if     wk ();
   wfsc_state_t     state_reg;
   wfsc_state_t     state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic            cnt_done;
   logic            psw_en_reg;
   logic            vreg_en_reg;
   logic            core_rst_reg;
   logic            core_en_reg;
   logic            sram_en_reg;
   logic            frc_en_reg;
   wfsc_frc_freq_t  frc_freq_reg;
   logic            main_clk_frc_reg;
   logic            cpu_en_reg;
   logic            xtal_en_reg;
   logic            slow_xtal_reg;

   wfsc_wake_detect u_detect (
      .mclk_in       (mclk_in),
      .rst_in        (rst_in),
      .wake_src_n_in ({real_time_timer_wake_n_in, rtc_wake_n_in, supply_monitor_wake_n_in, wake_pin_input_n_in}),
      .sleep_mode_in (sleep_mode_in),
      .wk            (wk.detector)
   );

   function automatic wfsc_frc_freq_t frc_decode(input logic [1:0] code);
      case (code)
         WFSC_FRC_8MHZ:  frc_decode = WFSC_FRC_8MHZ;
         WFSC_FRC_12MHZ: frc_decode = WFSC_FRC_12MHZ;
         default: frc_decode = WFSC_FRC_4MHZ;
      endcase
   endfunction : frc_decode

   assign fast_startup_out = wk.wake_async;
   assign cnt_done         = (cnt_reg == CNT_ONE);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         WFSC_ST_PSW:    if (cnt_done) state_next = WFSC_ST_VREG;
         WFSC_ST_VREG:   if (cnt_done) state_next = WFSC_ST_RST;
         WFSC_ST_RST:    state_next = WFSC_ST_IDLE;
         WFSC_ST_IDLE: begin
            if (wk.wake_sync && (!core_en_reg || !sram_en_reg)) begin
               state_next = WFSC_ST_SUPPLY;
            end else if (wk.wake_sync && sleep_mode_in) begin
               state_next = WFSC_ST_FRC;
            end
         end
         WFSC_ST_SUPPLY: if (cnt_done) state_next = WFSC_ST_FRC;
         WFSC_ST_FRC:    if (cnt_done) state_next = WFSC_ST_CLKSW;
         WFSC_ST_CLKSW:  if (main_system_clock_done_in) state_next = WFSC_ST_CPU;
         WFSC_ST_CPU:    state_next = WFSC_ST_IDLE;
         default:        state_next = WFSC_ST_PSW;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_reg <= WFSC_ST_PSW;
      end else begin
         state_reg <= state_next;
      end
   end

   // one down-counter serves every settle interval; loaded on entry to a timed state
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_reg <= PSW_CYC;
      end else if (state_next != state_reg) begin
         case (state_next)
            WFSC_ST_VREG:   cnt_reg <= VREG_CYC;
            WFSC_ST_SUPPLY: cnt_reg <= SUPPLY_CYC;
            WFSC_ST_FRC:    cnt_reg <= FRC_CYC;
            default:        cnt_reg <= CNT_ZERO;
         endcase
      end else if (cnt_reg != CNT_ZERO) begin
         cnt_reg <= cnt_reg - CNT_ONE;
      end
   end

   // power-up order: switches, regulator, then core reset release
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         psw_en_reg   <= 1'b0;
         vreg_en_reg  <= 1'b0;
         core_rst_reg <= 1'b1;
      end else begin
         if (state_reg == WFSC_ST_PSW) begin
            psw_en_reg <= 1'b1;
         end
         if (state_reg == WFSC_ST_VREG) begin
            vreg_en_reg <= 1'b1;
         end
         if (state_reg == WFSC_ST_RST) begin
            core_rst_reg <= 1'b0;
         end
      end
   end

   // backup entry drops both supplies; a wake only turns on what is off
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         core_en_reg <= 1'b1;
         sram_en_reg <= 1'b1;
      end else if (state_reg == WFSC_ST_SUPPLY) begin
         if (!core_en_reg) core_en_reg <= 1'b1;
         if (!sram_en_reg) sram_en_reg <= 1'b1;
      end else if (state_reg == WFSC_ST_IDLE && backup_req_in && !wk.wake_sync) begin
         core_en_reg <= 1'b0;
         sram_en_reg <= 1'b0;
      end
   end

   // fast RC: software picks the frequency, a fast restart forces 4 MHz
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         frc_en_reg   <= 1'b1;
         frc_freq_reg <= WFSC_FRC_4MHZ;
      end else if (state_reg == WFSC_ST_FRC) begin
         frc_en_reg   <= 1'b1;
         frc_freq_reg <= WFSC_FRC_4MHZ;
      end else if (state_reg == WFSC_ST_IDLE) begin
         frc_freq_reg <= frc_decode(frc_freq_req_in);
         // the fast RC is stopped in sleep; only a fast restart brings it back
         if (sleep_mode_in) frc_en_reg <= 1'b0;
      end
   end

   // master clock is kept off the fast RC while it restarts, then switched back onto it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         main_clk_frc_reg <= 1'b1;
      end else if (state_reg == WFSC_ST_FRC) begin
         main_clk_frc_reg <= 1'b0;
      end else if (state_reg == WFSC_ST_CLKSW) begin
         main_clk_frc_reg <= 1'b1;
      end
   end

   // processor clock stops in sleep and returns only after the switch is done
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cpu_en_reg <= 1'b0;
      end else if (state_reg == WFSC_ST_RST) begin
         cpu_en_reg <= 1'b1;
      end else if (state_reg == WFSC_ST_CPU) begin
         cpu_en_reg <= 1'b1;
      end else if (state_reg == WFSC_ST_SUPPLY) begin
         // a wake from backup also restarts the clock, so the processor clock waits too
         cpu_en_reg <= 1'b0;
      end else if (state_reg == WFSC_ST_IDLE && sleep_mode_in) begin
         cpu_en_reg <= 1'b0;
      end
   end

   // selecting the crystal without it running would stall the slow clock, so it is gated
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         xtal_en_reg   <= 1'b0;
         slow_xtal_reg <= 1'b0;
      end else begin
         xtal_en_reg   <= xtal32_en_req_in;
         slow_xtal_reg <= xtal32_sel_req_in && xtal32_en_req_in && xtal_en_reg;
      end
   end

   assign psw_en_out         = psw_en_reg;
   assign vreg_en_out        = vreg_en_reg;
   assign core_rst_out       = core_rst_reg;
   assign core_supply_en_out = core_en_reg;
   assign sram_supply_en_out = sram_en_reg;
   assign frc_en_out         = frc_en_reg;
   assign frc_freq_sel_out   = frc_freq_reg;
   assign main_system_clock_frc_out = main_clk_frc_reg;
   assign cpu_clk_en_out     = cpu_en_reg;
   assign xtal32_en_out      = xtal_en_reg;
   assign slow_sel_xtal_out  = slow_xtal_reg;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_async_request: assert property (
      (sleep_mode_in && !(&wake_pin_input_n_in)) |-> fast_startup_out)
      else $error("fast start-up request missing while a wake pin is low");
   a_wake_restart: assert property (
      (state_reg == WFSC_ST_IDLE && sleep_mode_in && wk.wake_sync && core_en_reg && sram_en_reg)
      |=> state_reg == WFSC_ST_FRC)
      else $error("wake during sleep did not start the fast restart");
   a_frc_four_mhz: assert property (
      (state_reg == WFSC_ST_CLKSW) |-> frc_freq_sel_out == WFSC_FRC_4MHZ && frc_en_out)
      else $error("master clock switch without fast RC at 4 MHz");
   a_cpu_after_switch: assert property (
      ($rose(cpu_clk_en_out) && $past(state_reg) != WFSC_ST_RST)
      |-> $past(state_reg) == WFSC_ST_CPU && $past(main_system_clock_done_in, 2) && main_system_clock_frc_out)
      else $error("processor clock enabled before master clock switch");
   a_cpu_held_off: assert property (
      (state_reg == WFSC_ST_FRC) |-> !cpu_clk_en_out)
      else $error("processor clock running during fast RC restart");
   a_supply_restore: assert property (
      (state_reg == WFSC_ST_IDLE && wk.wake_sync && !core_en_reg)
      |-> ##[2:60] core_supply_en_out && sram_supply_en_out)
      else $error("supplies not restored after wake from backup");
   a_power_order: assert property (
      !core_rst_out |-> vreg_en_out && psw_en_out)
      else $error("core reset released before supplies were up");
   a_vreg_late: assert property (
      $rose(vreg_en_out) |-> $past(state_reg) == WFSC_ST_VREG && $past(psw_en_out, 2))
      else $error("regulator enabled out of order");
   a_slow_default: assert property (
      $fell(rst_in) |-> !slow_sel_xtal_out ##1 !slow_sel_xtal_out)
      else $error("slow clock not on RC after reset");
   a_slow_gated: assert property (
      slow_sel_xtal_out |-> xtal32_en_out)
      else $error("crystal selected while disabled");
   a_frc_default: assert property (
      $fell(rst_in) |-> frc_freq_sel_out == WFSC_FRC_4MHZ)
      else $error("fast RC not at 4 MHz after reset");

   c_fast_restart: cover property (state_reg == WFSC_ST_CLKSW ##[1:20] state_reg == WFSC_ST_CPU);
   c_backup_wake:  cover property (state_reg == WFSC_ST_SUPPLY ##[1:80] state_reg == WFSC_ST_CPU);
   c_xtal_select:  cover property ($rose(slow_sel_xtal_out));
   c_freq_twelve:  cover property (frc_freq_sel_out == WFSC_FRC_12MHZ);
endmodule : wfsc_ctrl

// ---- core/wfsc_pkg.sv ----
// constants, states and behaviour summary for the wake-up and fast start-up controller
// Behaviour
// - wake source low during wait/sleep starts restart
// - fast start-up request is clockless, immediate
// - restart fast RC, master clock to 4 MHz
// - wake exits backup, restores disabled core/SRAM supplies
// - slow clock RC after reset, crystal by choice
// - power switches, then regulator, then core reset
// - fast RC offers 4/8/12 MHz, 4 MHz default
package wfsc_pkg;
   localparam int          WAKE_PINS     = 16;
   localparam int          WAKE_SRCS     = 19;
   localparam int          CLK_PERIOD_NS = 20;
   // settle times in ns, turned into whole cycles rounded up
   localparam int          T_PSW_NS      = 1000;
   localparam int          T_VREG_NS     = 1000;
   localparam int          T_FRC_NS      = 1000;
   localparam int          T_SUPPLY_NS   = 1000;
   localparam int          CNT_W         = 8;
   localparam int          PSW_CYC_I     = (T_PSW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          VREG_CYC_I    = (T_VREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FRC_CYC_I     = (T_FRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SUPPLY_CYC_I  = (T_SUPPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  PSW_CYC       = PSW_CYC_I[7:0];
   localparam logic [7:0]  VREG_CYC      = VREG_CYC_I[7:0];
   localparam logic [7:0]  FRC_CYC       = FRC_CYC_I[7:0];
   localparam logic [7:0]  SUPPLY_CYC    = SUPPLY_CYC_I[7:0];
   localparam logic [7:0]  CNT_ZERO      = 8'h00;
   localparam logic [7:0]  CNT_ONE       = 8'h01;

   typedef enum logic [1:0] {
      WFSC_FRC_4MHZ  = 2'h0,
      WFSC_FRC_8MHZ  = 2'h1,
      WFSC_FRC_12MHZ = 2'h2
   } wfsc_frc_freq_t;

   typedef enum logic [2:0] {
      WFSC_ST_PSW    = 3'h0,
      WFSC_ST_VREG   = 3'h1,
      WFSC_ST_RST    = 3'h3,
      WFSC_ST_IDLE   = 3'h2,
      WFSC_ST_FRC    = 3'h6,
      WFSC_ST_CLKSW  = 3'h7,
      WFSC_ST_CPU    = 3'h5,
      WFSC_ST_SUPPLY = 3'h4
   } wfsc_state_t;
endpackage : wfsc_pkg

// ---- core/wfsc_wake_if.sv ----
// carrier between the wake detector and the sequencer
`timescale 1ns/10ps
interface wfsc_wake_if;
   logic wake_async;
   logic wake_sync;
   modport detector  (output wake_async, output wake_sync);
   modport sequencer (input wake_async, input wake_sync);
endinterface : wfsc_wake_if

// ---- core/wfsc_wake_detect.sv ----
// wake source detection: clockless request path plus synchronised copy
`timescale 1ns/10ps
module wfsc_wake_detect
   import wfsc_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   input  wire logic [WAKE_SRCS-1:0] wake_src_n_in,
   input  wire logic                 sleep_mode_in,
   wfsc_wake_if.detector             wk
);
   logic [WAKE_SRCS-1:0] lvl_all;

   // purely combinational so the request still fires with every clock stopped
   assign wk.wake_async = sleep_mode_in & ~(&wake_src_n_in);

   genvar g;
   generate
      for (g = 0; g < WAKE_SRCS; g++) begin : g_sync
         // one private chain per source keeps every flop to a single process
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic lvl_reg;
         always_ff @(posedge mclk_in) begin
            if (rst_in) begin
               s1_reg  <= 1'b1;
               s2_reg  <= 1'b1;
               s3_reg  <= 1'b1;
               lvl_reg <= 1'b1;
            end else begin
               s1_reg <= wake_src_n_in[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               // a level change counts only once two stages agree
               if (s2_reg == s3_reg) begin
                  lvl_reg <= s3_reg;
               end
            end
         end
         assign lvl_all[g] = lvl_reg;
      end
   endgenerate

   assign wk.wake_sync = ~(&lvl_all);
endmodule : wfsc_wake_detect

// ---- verification/wfsc_far_side_model.sv ----
// wake sources and clock generator switch handshake facing the controller
`timescale 1ns/10ps
module wfsc_far_side_model
   import wfsc_pkg::*;
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   input  wire logic [WAKE_SRCS-1:0] wake_req_in,
   input  wire logic [8:0]           done_delay_in,
   input  wire logic                 clk_sel_frc_in,
   output logic      [WAKE_PINS-1:0] wake_pin_n_out,
   output logic                      supply_monitor_wake_n_out,
   output logic                      rtc_wake_n_out,
   output logic                      real_time_timer_wake_n_out,
   output logic                      clk_switch_done_out
);
   logic [8:0] wait_reg;

   // every source pulls its line low while it wants a wake
   assign {real_time_timer_wake_n_out, rtc_wake_n_out, supply_monitor_wake_n_out, wake_pin_n_out} =
      ~wake_req_in;

   // a slow clock generator: done follows the switch request only after the chosen delay
   always_ff @(posedge mclk_in) begin
      if (rst_in || !clk_sel_frc_in) begin
         wait_reg            <= 9'h000;
         clk_switch_done_out <= 1'b0;
      end else begin
         if (wait_reg != 9'h1FF) begin
            wait_reg <= wait_reg + 9'h001;
         end
         clk_switch_done_out <= (wait_reg >= done_delay_in);
      end
   end
endmodule : wfsc_far_side_model

// ---- verification/wfsc_ctrl_tb_top.sv ----
// self-checking bench for the wake-up and fast start-up controller
`timescale 1ns/10ps
module wfsc_ctrl_tb_top;
   import wfsc_pkg::*;
   logic                 mclk_in;
   logic                 rst_in;
   logic [WAKE_SRCS-1:0] wake_req;
   logic [8:0]           done_delay;
   logic [WAKE_PINS-1:0] pin_n;
   logic                 smon_n, rtc_n, timer_n, done;
   logic                 sleep, backup, xen, xsel;
   logic [1:0]           freq_req;
   logic                 fsu, psw, vreg, crst, csup, ssup, frc_en, msc_frc, cpu, xtal, slow_x;
   logic [1:0]           freq_sel;
   int                   mismatches;
   int                   n_compared;
   int                   cycles;

   wfsc_far_side_model FAR (.mclk_in(mclk_in), .rst_in(rst_in), .wake_req_in(wake_req),
      .done_delay_in(done_delay), .clk_sel_frc_in(msc_frc), .wake_pin_n_out(pin_n),
      .supply_monitor_wake_n_out(smon_n), .rtc_wake_n_out(rtc_n),
      .real_time_timer_wake_n_out(timer_n), .clk_switch_done_out(done));

   wfsc_ctrl DUT (.mclk_in(mclk_in), .rst_in(rst_in), .wake_pin_input_n_in(pin_n),
      .supply_monitor_wake_n_in(smon_n), .rtc_wake_n_in(rtc_n), .real_time_timer_wake_n_in(timer_n),
      .sleep_mode_in(sleep), .backup_req_in(backup), .main_system_clock_done_in(done),
      .frc_freq_req_in(freq_req), .xtal32_en_req_in(xen), .xtal32_sel_req_in(xsel),
      .fast_startup_out(fsu), .psw_en_out(psw), .vreg_en_out(vreg), .core_rst_out(crst),
      .core_supply_en_out(csup), .sram_supply_en_out(ssup), .frc_en_out(frc_en),
      .frc_freq_sel_out(freq_sel), .main_system_clock_frc_out(msc_frc), .cpu_clk_en_out(cpu),
      .xtal32_en_out(xtal), .slow_sel_xtal_out(slow_x));

   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : cyc

   // power-up order and reset defaults
   task automatic t_power_up;
      chk(psw, 1'b0);
      chk(vreg, 1'b0);
      chk(crst, 1'b1);
      chk(freq_sel, WFSC_FRC_4MHZ);
      chk({xtal, slow_x}, 2'h0);
      rst_in = 1'b0;
      cyc(1);
      chk({psw, vreg}, 2'h2);
      for (int i = 0; i < 200 && vreg !== 1'b1; i++) cyc(1);
      chk({psw, vreg, crst}, 3'h7);
      for (int i = 0; i < 200 && crst !== 1'b0; i++) cyc(1);
      chk({vreg, crst, cpu}, 3'h5);
      $display("test power_up done");
   endtask : t_power_up

   // every frequency code, then every source drives the request without a clock
   task automatic t_sources;
      for (int c = 0; c < 4; c++) begin
         freq_req = c[1:0];
         cyc(2);
         chk(freq_sel, (c == 3) ? 2'h0 : c[1:0]);
      end
      wake_req = 19'h00001;
      #1 chk(fsu, 1'b0);
      wake_req = '0;
      sleep    = 1'b1;
      cyc(3);
      chk({fsu, cpu, frc_en}, 3'h0);
      for (int s = 0; s < WAKE_SRCS; s++) begin
         wake_req    = '0;
         wake_req[s] = 1'b1;
         #1 chk(fsu, 1'b1);
         wake_req = '0;
         #1 chk(fsu, 1'b0);
         cyc(1);
      end
      $display("test sources done");
   endtask : t_sources

   // restart from sleep with a slow clock switch
   task automatic t_restart;
      int n;
      freq_req     = 2'h2;
      done_delay   = 9'd150;
      cyc(1);
      wake_req[12] = 1'b1;
      #1 chk(fsu, 1'b1);
      for (n = 0; n < 500 && cpu !== 1'b1; n++) begin
         cyc(1);
         if (n == 10) sleep = 1'b0;
         if (n == 100) chk({frc_en, msc_frc, freq_sel}, 4'hC);
      end
      chk(done, 1'b1);
      chk(n >= 150, 1'b1);
      wake_req = '0;
      freq_req = 2'h0;
      // the wake synchroniser needs several edges to drain, or backup would be refused
      cyc(8);
      $display("test restart done");
   endtask : t_restart

   // backup drops both supplies, a wake restores them
   task automatic t_backup;
      int n;
      done_delay = 9'd5;
      backup     = 1'b1;
      cyc(2);
      backup = 1'b0;
      chk({csup, ssup}, 2'h0);
      cyc(5);
      chk({csup, ssup}, 2'h0);
      wake_req[18] = 1'b1;
      for (n = 0; n < 20 && csup !== 1'b1; n++) cyc(1);
      chk({csup, ssup}, 2'h3);
      cyc(200);
      chk({cpu, msc_frc, freq_sel}, 4'hC);
      wake_req = '0;
      cyc(2);
      chk({csup, ssup}, 2'h3);
      $display("test backup done");
   endtask : t_backup

   // slow clock source selection
   task automatic t_slow_clock;
      xsel = 1'b1;
      cyc(3);
      chk(slow_x, 1'b0);
      xen = 1'b1;
      cyc(1);
      chk(xtal, 1'b1);
      cyc(3);
      chk(slow_x, 1'b1);
      xen = 1'b0;
      cyc(3);
      chk({xtal, slow_x}, 2'h0);
      $display("test slow_clock done");
   endtask : t_slow_clock

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   initial begin
      {mismatches, n_compared, cycles} = '0;
      rst_in     = 1'b1;
      wake_req   = '0;
      done_delay = 9'd1;
      {sleep, backup, xen, xsel} = 4'h0;
      freq_req   = 2'h0;
      cyc(6);
      t_power_up();
      t_sources();
      t_restart();
      t_backup();
      t_slow_clock();
      finish_test();
   end
endmodule : wfsc_ctrl_tb_top
